// ===== far_phy.sv
`timescale 1ns/1ns
// far end phy: recovered clock and ternary stream on the cable
module far_phy #(
    parameter int HALF = 6
) (
    input  wire logic       pclk,       // system clock
    input  wire logic       run,        // partner sending frames
    input  wire logic       rcvr_ok,    // receiver converged
    output logic            rx_clk_pin, // recovered clock
    output logic [1:0]      rx_pair,    // ternary symbol
    output logic            eq_ok_pin,  // equaliser converged
    output logic            ec_ok_pin,  // canceller converged
    output logic [1:0]      held_sym    // symbol at last rising edge
);
    int cnt = 0;

    assign eq_ok_pin = rcvr_ok;
    assign ec_ok_pin = rcvr_ok;

    // clock stands still when idle; symbol moves away from the rising edge
    always @(posedge pclk) begin
        if (!run) begin
            cnt <= 0;
            rx_clk_pin <= 1'b0;
            rx_pair <= 2'h0;
            held_sym <= 2'h0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            rx_clk_pin <= !rx_clk_pin;
            if (rx_clk_pin)
                rx_pair <= (rx_pair == 2'h2) ? 2'h0 : rx_pair + 2'h1;
            else
                held_sym <= rx_pair;
        end else
            cnt <= cnt + 1;
    end
endmodule

// ===== pma_consts.svh
`ifndef PMA_CONSTS_SVH
`define PMA_CONSTS_SVH

// register byte offsets
`define OFS_CTRL      12'h000
`define OFS_STAT      12'h004
`define OFS_INT_STAT  12'h008
`define OFS_INT_MASK  12'h00c

// control register fields
`define CTRL_MASTER   0
`define CTRL_LINK_EN  1
`define CTRL_SOFT_RST 2
`define MASTER_RST    1'b1
`define LINK_EN_RST   1'b1

// interrupt status fields
`define IRQ_LINK_UP   0
`define IRQ_LINK_DOWN 1
`define IRQ_MAXWAIT   2
`define IRQ_RCVR_LOST 3
`define IRQ_W         4

// timing: clock rate and printed times
`define CLK_KHZ       20000
`define MAXWAIT_M_MS  1406
`define MAXWAIT_S_MS  656
`define STAB_NS       1800
`define STAB_CYC      ((`STAB_NS * `CLK_KHZ + 999999) / 1000000)
`define LOCAL_DIV     4

// ternary symbol codes
`define SYM_ZERO      2'h0

`endif

// ===== pma_link_ctrl.sv
`timescale 1ns/1ns
`include "pma_consts.svh"
module pma_link_ctrl
    import pma_pkg::*;
#(
    parameter int unsigned MAXWAIT_M_CYC = `MAXWAIT_M_MS * `CLK_KHZ,
    parameter int unsigned MAXWAIT_S_CYC = `MAXWAIT_S_MS * `CLK_KHZ
) (
    input  wire logic        pclk,            // 20 MHz clock
    input  wire logic        presetn,         // async reset, active low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error, unmapped
    output logic             irq,             // level interrupt
    input  wire logic [1:0]  tx_symb_vector,  // symbol from coding tx
    output logic             tx_symb_take,    // pulse: symbol taken
    output logic [1:0]       tx_pair,         // symbol to transmitter
    input  wire logic        rx_clk_pin,      // recovered clock pin
    input  wire logic [1:0]  rx_pair,         // sliced receive symbol pin
    input  wire logic        eq_ok_pin,       // equaliser converged pin
    input  wire logic        ec_ok_pin,       // echo canceller pin
    output logic [1:0]       rx_symb_vector,  // symbol to coding rx
    output logic             rx_symb_strobe,  // pulse: new rx symbol
    input  wire logic        scr_status,      // descrambler locked
    input  wire logic        rem_rcvr_status, // remote receiver ok
    output logic             loc_rcvr_status, // local receiver ok
    output logic [1:0]       tx_mode,         // coded tx mode
    output logic             tx_enable_ok,    // control: data allowed
    output logic             link_status,     // link ok
    output logic             pma_reset        // attachment reset
);
////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every pin input
    logic [5:0] sy1_q, sy2_q;
    logic       rclk_d1_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q     <= 6'h00;
            sy2_q     <= 6'h00;
            rclk_d1_q <= 1'b0;
        end else begin
            sy1_q     <= {rx_clk_pin, rx_pair, eq_ok_pin, ec_ok_pin, 1'b0};
            sy2_q     <= sy1_q;
            rclk_d1_q <= sy2_q[5];
        end
    end
    // recovered sampling tick on the rising edge of the synced clock
    logic rec_tick;
    assign rec_tick = sy2_q[5] & ~rclk_d1_q;
////////////////////////////////////////////////////////////////////////////
    // apb slave and registers
    logic [2:0]         ctrl_q, ctrl_d;
    logic [`IRQ_W-1:0]  ist_q, ist_d, imsk_q, imsk_d, ev;
    logic [31:0]        rdat_q, rdat_d;
    logic               rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
    logic               wr_acc, hit;
    logic [31:0]        stat_w;
    assign wr_acc = psel & penable & pwrite & rdy_q;
    always_comb begin
        ctrl_d = ctrl_q;
        ist_d  = ist_q;
        imsk_d = imsk_q;
        rdy_d  = psel & ~penable;
        rdat_d = rdat_q;
        hit    = 1'b1;
        case (paddr)
            `OFS_CTRL:     rdat_d = {29'h0, ctrl_q};
            `OFS_STAT:     rdat_d = stat_w;
            `OFS_INT_STAT: rdat_d = {28'h0, ist_q};
            `OFS_INT_MASK: rdat_d = {28'h0, imsk_q};
            default: begin
                rdat_d = 32'h0;
                hit    = 1'b0;
            end
        endcase
        err_d = psel & ~penable & ~hit;
        if (wr_acc && paddr == `OFS_CTRL) begin
            ctrl_d = pwdata[2:0];
        end
        if (wr_acc && paddr == `OFS_INT_MASK) begin
            imsk_d = pwdata[`IRQ_W-1:0];
        end
        if (wr_acc && paddr == `OFS_INT_STAT) begin
            ist_d = ist_d & ~pwdata[`IRQ_W-1:0];
        end
        ist_d = ist_d | ev; // set wins over clear
        irq_d = |(ist_d & imsk_d);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= {1'b0, `LINK_EN_RST, `MASTER_RST};
            ist_q  <= 4'h0;
            imsk_q <= 4'h0;
            rdat_q <= 32'h0;
            rdy_q  <= 1'b0;
            err_q  <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ist_q  <= ist_d;
            imsk_q <= imsk_d;
            rdat_q <= rdat_d;
            rdy_q  <= rdy_d;
            err_q  <= err_d;
            irq_q  <= irq_d;
        end
    end
    assign prdata  = rdat_q;
    assign pready  = rdy_q;
    assign pslverr = err_q;
    assign irq     = irq_q;

    logic is_master, link_en, rst_int;
    assign is_master = ctrl_q[`CTRL_MASTER];
    assign link_en   = ctrl_q[`CTRL_LINK_EN];
    // attachment reset: pin reset or soft reset, no low-power terms
    assign rst_int   = ctrl_q[`CTRL_SOFT_RST];
////////////////////////////////////////////////////////////////////////////
    // phy control: state, tx mode and maxwait timer
    ctrl_state_t st_q, st_d;
    tx_mode_t    mode_q, mode_d;
    logic [24:0] mw_q, mw_d;
    logic        mw_done, loc_ok_q, loc_ok_d, rst_q, ten_q, ten_d;
    logic        lnk_q, lm_up_ev, lm_dn_ev;
    assign mw_done = (mw_q == 25'h0);
    always_comb begin
        st_d  = st_q;
        mw_d  = mw_done ? mw_q : mw_q - 25'h1;
        ev    = 4'h0;
        // local receiver status from equaliser and echo canceller
        loc_ok_d = sy2_q[2] & sy2_q[1] & ~rst_int;
        case (st_q)
            ST_DISABLE: begin
                mw_d = is_master ? MAXWAIT_M_CYC[24:0]
                                 : MAXWAIT_S_CYC[24:0];
                st_d = is_master ? ST_TRAINING : ST_SLAVE_SILENT;
            end
            ST_SLAVE_SILENT: begin
                if (scr_status) begin
                    st_d = ST_TRAINING;
                end
            end
            ST_TRAINING: begin
                if (loc_ok_q) begin
                    st_d = ST_SEND_IDLE;
                end
            end
            ST_SEND_IDLE: begin
                if (!loc_ok_q) begin
                    st_d = ST_TRAINING;
                end else if (rem_rcvr_status) begin
                    st_d = ST_SEND_DATA;
                end
            end
            ST_SEND_DATA: begin
                if (!loc_ok_q || !rem_rcvr_status) begin
                    st_d = ST_SEND_IDLE;
                end
            end
            default: st_d = ST_DISABLE;
        endcase
        // maxwait expiry without link returns to disable and raises the maxwait event
        if (mw_done && !lnk_q && st_q != ST_DISABLE) begin
            st_d = ST_DISABLE;
            ev[`IRQ_MAXWAIT] = 1'b1;
        end
        if (lnk_q) begin
            mw_d = mw_q;
        end
        if (!link_en || rst_int) begin
            st_d = ST_DISABLE;
        end
        case (st_d)
            ST_SEND_DATA:               mode_d = SEND_N;
            ST_TRAINING, ST_SEND_IDLE:  mode_d = SEND_I;
            default:                    mode_d = SEND_Z;
        endcase
        ten_d = (st_d == ST_SEND_DATA) & loc_ok_d;
        ev[`IRQ_RCVR_LOST] = loc_ok_q & ~loc_ok_d;
        ev[`IRQ_LINK_UP]   = lm_up_ev;
        ev[`IRQ_LINK_DOWN] = lm_dn_ev;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= ST_DISABLE;
            mode_q   <= SEND_Z;
            mw_q     <= 25'h0;
            loc_ok_q <= 1'b0;
            ten_q    <= 1'b0;
            rst_q    <= 1'b1;
        end else begin
            st_q     <= st_d;
            mode_q   <= mode_d;
            mw_q     <= mw_d;
            loc_ok_q <= loc_ok_d;
            ten_q    <= ten_d;
            rst_q    <= rst_int;
        end
    end
    // status goes to coding tx, coding rx, control and link monitor
    assign loc_rcvr_status = loc_ok_q;
    assign tx_mode         = mode_q;
    assign tx_enable_ok    = ten_q;
    assign pma_reset       = rst_q;
////////////////////////////////////////////////////////////////////////////
    // link monitor: stabilise then up, no auto-negotiation terms
    lmon_state_t lm_q, lm_d;
    logic [5:0]  stab_q, stab_d;
    logic        lnk_d;
    always_comb begin
        lm_d   = lm_q;
        stab_d = stab_q;
        case (lm_q)
            LM_DOWN: begin
                stab_d = 6'(`STAB_CYC - 1);
                if (loc_ok_q) begin
                    lm_d = LM_HOLD;
                end
            end
            LM_HOLD: begin
                stab_d = stab_q - 6'h1;
                if (!loc_ok_q) begin
                    lm_d = LM_DOWN;
                end else if (stab_q == 6'h0) begin
                    lm_d = LM_UP;
                end
            end
            LM_UP: begin
                if (!loc_ok_q) begin
                    lm_d = LM_DOWN;
                end
            end
            default: lm_d = LM_DOWN;
        endcase
        if (!link_en || rst_int) begin
            lm_d = LM_DOWN;
        end
        lnk_d    = (lm_d == LM_UP);
        lm_up_ev = lnk_d & ~lnk_q;
        lm_dn_ev = lnk_q & ~lnk_d;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lm_q   <= LM_DOWN;
            stab_q <= 6'h0;
            lnk_q  <= 1'b0;
        end else begin
            lm_q   <= lm_d;
            stab_q <= stab_d;
            lnk_q  <= lnk_d;
        end
    end
    assign link_status = lnk_q;
    assign stat_w = {24'h0, st_q, lnk_q, loc_ok_q, 1'b0, mode_q};
////////////////////////////////////////////////////////////////////////////
    // symbol datapath: tx on local tick for master, recovered tick for slave; rx always on recovered tick
    logic [2:0] div_q, div_d;
    logic [1:0] txp_q, txp_d, rxv_q, rxv_d;
    logic       tk_q, tk_d, rxs_q, rxs_d, tx_tick;
    always_comb begin
        div_d   = (div_q == 3'(`LOCAL_DIV - 1)) ? 3'h0 : div_q + 3'h1;
        tx_tick = is_master ? (div_q == 3'h0)
                            : rec_tick;
        txp_d   = txp_q;
        tk_d    = 1'b0;
        if (tx_tick) begin
            tk_d  = 1'b1;
            txp_d = (mode_q == SEND_Z) ? `SYM_ZERO : tx_symb_vector;
        end
        rxv_d = rec_tick ? sy2_q[4:3] : rxv_q;
        rxs_d = rec_tick;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 3'h0;
            txp_q <= `SYM_ZERO;
            tk_q  <= 1'b0;
            rxv_q <= 2'h0;
            rxs_q <= 1'b0;
        end else begin
            div_q <= div_d;
            txp_q <= txp_d;
            tk_q  <= tk_d;
            rxv_q <= rxv_d;
            rxs_q <= rxs_d;
        end
    end
    assign tx_pair        = txp_q;
    assign tx_symb_take   = tk_q;
    assign rx_symb_vector = rxv_q;
    assign rx_symb_strobe = rxs_q;
////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mode_legal: assert property (mode_q != 2'h3)
        else $error("tx mode out of range");
    a_zero_when_off: assert property ((!link_en || rst_int) |=>
        mode_q == SEND_Z) else $error("tx mode not zero while off");
    a_master_tick: assert property (is_master && div_q == 3'h0
        && $stable(is_master) |=> tk_q) else $error("master tick lost");
    a_slave_tick: assert property (!is_master && rec_tick
        |=> tk_q) else $error("slave tick lost");
    a_tx_zero: assert property (tk_q && $past(mode_q) == SEND_Z
        |-> tx_pair == `SYM_ZERO) else $error("non zero symbol sent");
    a_rx_pass: assert property (rec_tick |=>
        rxs_q && rxv_q == $past(sy2_q[4:3])) else $error("rx symbol lost");
    a_rcvr_src: assert property (!sy2_q[2] |=> !loc_ok_q)
        else $error("receiver ok without equaliser");
    a_data_needs: assert property (ten_q |-> loc_ok_q)
        else $error("data mode without receiver ok");
    a_link_stab: assert property (lm_q == LM_DOWN ##1 lm_q == LM_HOLD
        |-> !lnk_q [*8]) else $error("link up before stabilise");
    a_role_wait: assert property (st_q == ST_DISABLE && link_en
        && !rst_int |=> mw_q == (is_master ? MAXWAIT_M_CYC[24:0]
        : MAXWAIT_S_CYC[24:0])) else $error("maxwait load wrong");
endmodule

// ===== pma_pkg.sv
package pma_pkg;
    typedef enum logic [1:0] {SEND_Z, SEND_I, SEND_N} tx_mode_t;
    typedef enum logic [2:0] {
        ST_DISABLE, ST_SLAVE_SILENT, ST_TRAINING, ST_SEND_IDLE, ST_SEND_DATA
    } ctrl_state_t;
    typedef enum logic [1:0] {LM_DOWN, LM_HOLD, LM_UP} lmon_state_t;
endpackage

// ===== tb_pma_link_ctrl.sv
`timescale 1ns/1ns
`include "pma_consts.svh"
module tb_pma_link_ctrl;
    import pma_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  tx_symb_vector = 2'h0;
    logic        scr_status = 1'b0;
    logic        rem_rcvr_status = 1'b0;
    logic        run = 1'b0;
    logic        rcvr_ok = 1'b0;
    logic        tx_on = 1'b0;
    logic [31:0] prdata, rd;
    logic [1:0]  tx_pair, rx_pair, rx_symb_vector, tx_mode, held_sym, v;
    logic        pready, pslverr, irq, tx_symb_take, rx_clk_pin, err;
    logic        eq_ok_pin, ec_ok_pin, rx_symb_strobe, loc_rcvr_status;
    logic        tx_enable_ok, link_status, pma_reset;
    logic [1:0]  txq[$];
    int          mismatches = 0, n_compared = 0, cyc = 0, takes = 0;

    pma_link_ctrl #(.MAXWAIT_M_CYC(200), .MAXWAIT_S_CYC(100))
        pma_link_ctrl_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .tx_symb_vector, .tx_symb_take,
        .tx_pair, .rx_clk_pin, .rx_pair, .eq_ok_pin, .ec_ok_pin,
        .rx_symb_vector, .rx_symb_strobe, .scr_status, .rem_rcvr_status,
        .loc_rcvr_status, .tx_mode, .tx_enable_ok, .link_status,
        .pma_reset);

    far_phy far_phy_inst (.pclk, .run, .rcvr_ok, .rx_clk_pin, .rx_pair,
        .eq_ok_pin, .ec_ok_pin, .held_sym);

    always #25 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_mode(input logic [1:0] m);
        for (int i = 0; i < 3000 && tx_mode !== m; i++)
            @(posedge pclk);
        chk("tx_mode", tx_mode, m);
    endtask

    task automatic wait_lvl(input logic [1:0] m);
        for (int i = 0; i < 3000; i++) begin
            if ({link_status, loc_rcvr_status} === m)
                break;
            @(posedge pclk);
        end
        chk("link and rcvr", {link_status, loc_rcvr_status}, m);
    endtask

    task automatic rate(input int lo, input int hi);
        takes = 0;
        repeat (240) @(posedge pclk);
        chk("take rate", 32'(takes >= lo && takes <= hi), 32'h1);
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // symbol source: a fresh random symbol after each take, noted in txq
    always @(posedge pclk) begin
        if (!tx_on) begin
            txq.delete();
            tx_symb_vector <= 2'h2; // idle source parks a non-zero symbol
        end else if (tx_symb_take === 1'b1) begin
            v = 2'($urandom_range(2, 0));
            tx_symb_vector <= v;
            txq.push_back(v);
        end
    end

    // watcher: compares settled results mid-cycle
    always @(negedge pclk) begin
        if (tx_symb_take === 1'b1) begin
            takes++;
            if (txq.size() > 0)
                chk("tx_pair", tx_pair, txq.pop_front());
        end
        if (rx_symb_strobe === 1'b1 && run)
            chk("rx_symb_vector", rx_symb_vector, held_sym);
    end

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            $display("timeout");
            end_sim();
        end
    end

    initial begin
        void'($urandom(17));
        repeat (8) @(posedge pclk);
        chk("pma_reset", pma_reset, 1'b1);
        chk("tx_mode reset", tx_mode, SEND_Z);
        presetn <= 1'b1;
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk("ctrl", rd, 32'h3);
        apb(1'b0, `OFS_INT_MASK, 32'h0);
        chk("int_mask", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        $display("test 1 registers done");
        apb(1'b1, `OFS_INT_MASK, 32'h4);
        repeat (130) @(posedge pclk);
        apb(1'b0, `OFS_INT_STAT, 32'h0);
        chk("maxwait early", rd & 32'h4, 32'h0);
        chk("irq early", irq, 1'b0);
        repeat (70) @(posedge pclk);
        apb(1'b0, `OFS_INT_STAT, 32'h0);
        chk("maxwait set", rd & 32'h4, 32'h4);
        chk("irq set", irq, 1'b1);
        apb(1'b1, `OFS_INT_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, `OFS_INT_STAT, 32'h4);
        apb(1'b1, `OFS_INT_MASK, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq cleared", irq, 1'b0);
        apb(1'b1, `OFS_INT_MASK, 32'h0);
        $display("test 2 maxwait and interrupt done");
        rcvr_ok <= 1'b1;
        run <= 1'b1;
        scr_status <= 1'b1;
        for (int i = 0; i < 200 && loc_rcvr_status !== 1'b1; i++)
            @(posedge pclk);
        chk("loc ok", loc_rcvr_status, 1'b1);
        wait_mode(SEND_I);
        chk("tx_enable_ok idle", tx_enable_ok, 1'b0);
        rem_rcvr_status <= 1'b1;
        wait_mode(SEND_N);
        wait_lvl(2'b11);
        chk("tx_enable_ok data", tx_enable_ok, 1'b1);
        tx_on <= 1'b1;
        rate(59, 61);
        $display("test 3 master link done");
        tx_on <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h2);
        repeat (20) @(posedge pclk);
        wait_mode(SEND_N);
        tx_on <= 1'b1;
        rate(19, 21);
        $display("test 4 slave loop timing done");
        tx_on <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h0);
        wait_mode(SEND_Z);
        repeat (30) @(posedge pclk);
        chk("tx_pair zero", tx_pair, 2'h0);
        chk("tx_enable_ok off", tx_enable_ok, 1'b0);
        apb(1'b0, `OFS_STAT, 32'h0);
        chk("stat mode", rd & 32'h3, 32'h0);
        scr_status <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h2);
        repeat (20) @(posedge pclk);
        chk("slave silent", tx_mode, SEND_Z);
        scr_status <= 1'b1;
        wait_mode(SEND_N);
        $display("test 5 link disable done");
        apb(1'b1, `OFS_CTRL, 32'h7);
        repeat (3) @(posedge pclk);
        chk("pma_reset soft", pma_reset, 1'b1);
        chk("loc in reset", loc_rcvr_status, 1'b0);
        chk("mode in reset", tx_mode, SEND_Z);
        apb(1'b1, `OFS_CTRL, 32'h3);
        wait_mode(SEND_N);
        chk("pma_reset off", pma_reset, 1'b0);
        rcvr_ok <= 1'b0;
        wait_lvl(2'b00);
        $display("test 6 soft reset and loss done");
        end_sim();
    end
endmodule
